// File: fdcst_pkg.sv
// Constants, encodings and carrier types of the floppy status block
package fdcst_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [1:0] ADDR_STATUS_CMD = 2'h0;
    localparam logic [1:0] ADDR_DATA = 2'h1;
    localparam logic [1:0] ADDR_CTRL = 2'h2;
    localparam logic [7:0] RDATA_NONE = 8'h00;
    localparam int CTRL_MFM_BIT = 0;
    localparam int CTRL_SLOW_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // ****************************************
    // Status bit positions
    // ****************************************
    localparam int S_BUSY = 0;
    localparam int S_DRQ = 1;
    localparam int S_B2 = 2;
    localparam int S_CRC = 3;
    localparam int S_B4 = 4;
    localparam int S_B5 = 5;
    localparam int S_B6 = 6;
    localparam int S_NRDY = 7;

    // ****************************************
    // Command codes in the low bits of a command write
    // ****************************************
    localparam logic [2:0] CMD_POSITION = 3'h0;
    localparam logic [2:0] CMD_RD_ADDR = 3'h1;
    localparam logic [2:0] CMD_RD_SEC = 3'h2;
    localparam logic [2:0] CMD_RD_TRK = 3'h3;
    localparam logic [2:0] CMD_WR_SEC = 3'h4;
    localparam logic [2:0] CMD_WR_TRK = 3'h5;
    localparam logic [2:0] CMD_FORCE = 3'h6;

    typedef enum logic [5:0] {
        K_POS = 6'h01,
        K_RADDR = 6'h02,
        K_RSEC = 6'h04,
        K_RTRK = 6'h08,
        K_WSEC = 6'h10,
        K_WTRK = 6'h20
    } fdcst_kind_t;

    // ****************************************
    // Bit cell timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 5;
    localparam int CELL_MFM_NS = 2000;
    localparam int CELL_FM_NS = 4000;
    localparam int CELL_MFM_CYC = CELL_MFM_NS / CLK_PERIOD_NS;
    localparam int CELL_FM_CYC = CELL_FM_NS / CLK_PERIOD_NS;
    localparam int CELLS_PER_BYTE = 8;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fdcst_bus_t;

    typedef struct packed {
        logic done;
        logic seek_err;
        logic crc_err;
        logic record_not_found;
        logic deleted_mark;
        logic write_fault;
        logic byte_stb;
        logic [7:0] byte_val;
    } fdcst_ev_t;

endpackage

// File: fdcst_core.sv
// Status word, data holding register and bit cell timing of the controller
`timescale 1ns/10ps
`default_nettype none

module fdcst_core (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire fdcst_pkg::fdcst_bus_t bus,
    output logic [7:0] rdata,
    input wire fdcst_pkg::fdcst_ev_t ev,
    input wire logic ready_in,
    input wire logic master_reset_in,
    input wire logic write_protect_in_n,
    input wire logic head_settle_in,
    input wire logic track_zero_in_n,
    input wire logic index_pulse_in_n,
    output logic head_load_out,
    output logic byte_transfer_request,
    output logic command_done_irq,
    output logic bit_cell_en,
    output logic [7:0] data_to_engine
);

    // ****************************************
    // Bus decode
    // ****************************************
    wire logic sel_st = bus.addr == fdcst_pkg::ADDR_STATUS_CMD;
    wire logic sel_dr = bus.addr == fdcst_pkg::ADDR_DATA;
    wire logic sel_ct = bus.addr == fdcst_pkg::ADDR_CTRL;
    wire logic cmd_wr = bus.wr && sel_st;
    wire logic st_rd = bus.rd && sel_st;
    wire logic dr_acc = (bus.wr || bus.rd) && sel_dr;
    wire logic [2:0] cmd_code = bus.wdata[2:0];
    wire logic not_ready = !ready_in || master_reset_in;

    fdcst_pkg::fdcst_kind_t kind_q, kind_d;
    logic busy_q, drq_q, irq_q, hld_q, cell_q;
    logic b2_q, crc_q, b4_q, b5_q, b6_q;
    logic [1:0] ctrl_q;
    logic [7:0] dr_q, rdata_q;
    logic [10:0] cell_cnt_q;
    logic [2:0] byte_cnt_q;

    // ****************************************
    // Command acceptance
    // ****************************************
    wire logic is_force = cmd_code == fdcst_pkg::CMD_FORCE;
    wire logic is_pos = cmd_code == fdcst_pkg::CMD_POSITION;
    wire logic known = cmd_code <= fdcst_pkg::CMD_WR_TRK;
    // Types II and III never start on a drive that is not ready
    wire logic refused = cmd_wr && !is_pos && known && not_ready;
    wire logic start = cmd_wr && known && !refused && !busy_q;
    // Force with nothing running reverts to positioning status
    wire logic idle_force = cmd_wr && is_force && !busy_q;
    wire logic update = start || idle_force;
    wire logic is_write = kind_q == fdcst_pkg::K_WSEC
        || kind_q == fdcst_pkg::K_WTRK;
    wire logic is_xfer = kind_q != fdcst_pkg::K_POS;

    always_comb begin
        kind_d = kind_q;
        if (idle_force) begin
            kind_d = fdcst_pkg::K_POS;
        end else if (start) begin
            case (cmd_code)
                fdcst_pkg::CMD_POSITION: kind_d = fdcst_pkg::K_POS;
                fdcst_pkg::CMD_RD_ADDR: kind_d = fdcst_pkg::K_RADDR;
                fdcst_pkg::CMD_RD_SEC: kind_d = fdcst_pkg::K_RSEC;
                fdcst_pkg::CMD_RD_TRK: kind_d = fdcst_pkg::K_RTRK;
                fdcst_pkg::CMD_WR_SEC: kind_d = fdcst_pkg::K_WSEC;
                fdcst_pkg::CMD_WR_TRK: kind_d = fdcst_pkg::K_WTRK;
                default: kind_d = kind_q;
            endcase
        end
    end

    // ****************************************
    // Bit cell divider and byte timer
    // ****************************************
    wire logic mfm = ctrl_q[fdcst_pkg::CTRL_MFM_BIT];
    wire logic slow = ctrl_q[fdcst_pkg::CTRL_SLOW_BIT];
    wire logic [10:0] cell_base = mfm ? 11'(fdcst_pkg::CELL_MFM_CYC)
        : 11'(fdcst_pkg::CELL_FM_CYC);
    // A 1 MHz master clock doubles every cell
    wire logic [10:0] cell_len = slow ? 11'(cell_base << 1) : cell_base;
    // Compare by range so a rate change never lets the count run past
    wire logic cell_wrap = cell_cnt_q >= cell_len - 11'h001;
    wire logic byte_end = cell_wrap && drq_q && busy_q && byte_cnt_q ==
        3'(fdcst_pkg::CELLS_PER_BYTE - 1);
    wire logic lost_set = byte_end && is_xfer;

    // ****************************************
    // Request and error capture
    // ****************************************
    wire logic rd_kind = kind_q == fdcst_pkg::K_RSEC
        || kind_q == fdcst_pkg::K_RADDR || kind_q == fdcst_pkg::K_RTRK;
    wire logic byte_in = busy_q && ev.byte_stb && is_xfer;
    wire logic wr_start = start && (cmd_code == fdcst_pkg::CMD_WR_SEC
        || cmd_code == fdcst_pkg::CMD_WR_TRK);
    // A new request in the same cycle as an access wins over the clear
    wire logic drq_d = byte_in || wr_start
        || (drq_q && !dr_acc && !update && !ev.done);
    wire logic done = busy_q && (ev.done || (cmd_wr && is_force));
    wire logic busy_d = start || (busy_q && !done
        && !master_reset_in);
    wire logic irq_d = done || refused || (irq_q && !st_rd);
    wire logic err_ev = busy_q && !update;
    wire logic b4_d = !update && (b4_q || (err_ev
        && (ev.seek_err || ev.record_not_found)));
    wire logic crc_d = !update && (crc_q || (err_ev
        && ev.crc_err));
    wire logic b5_d = !update && (b5_q || (err_ev && ((ev.deleted_mark
        && kind_q == fdcst_pkg::K_RSEC)
        || (ev.write_fault && is_write))));
    wire logic b6_d = !update && (b6_q || (err_ev && is_write
        && !write_protect_in_n));
    wire logic b2_d = !update && (b2_q || lost_set);

    // ****************************************
    // Status assembly by command kind
    // ****************************************
    logic [7:0] status;
    always_comb begin
        status = 8'h00;
        status[fdcst_pkg::S_NRDY] = not_ready;
        status[fdcst_pkg::S_BUSY] = busy_q;
        case (kind_q)
            fdcst_pkg::K_POS: begin
                status[fdcst_pkg::S_B6] = !write_protect_in_n;
                status[fdcst_pkg::S_B5] = hld_q && head_settle_in;
                status[fdcst_pkg::S_B4] = b4_q;
                status[fdcst_pkg::S_CRC] = crc_q;
                status[fdcst_pkg::S_B2] = !track_zero_in_n;
                status[fdcst_pkg::S_DRQ] = !index_pulse_in_n;
            end
            fdcst_pkg::K_RADDR, fdcst_pkg::K_RSEC: begin
                status[fdcst_pkg::S_B5] = b5_q;
                status[fdcst_pkg::S_B4] = b4_q;
                status[fdcst_pkg::S_CRC] = crc_q;
                status[fdcst_pkg::S_B2] = b2_q;
                status[fdcst_pkg::S_DRQ] = drq_q;
            end
            fdcst_pkg::K_RTRK: begin
                status[fdcst_pkg::S_B2] = b2_q;
                status[fdcst_pkg::S_DRQ] = drq_q;
            end
            fdcst_pkg::K_WSEC: begin
                status[fdcst_pkg::S_B6] = b6_q;
                status[fdcst_pkg::S_B5] = b5_q;
                status[fdcst_pkg::S_B4] = b4_q;
                status[fdcst_pkg::S_CRC] = crc_q;
                status[fdcst_pkg::S_B2] = b2_q;
                status[fdcst_pkg::S_DRQ] = drq_q;
            end
            fdcst_pkg::K_WTRK: begin
                status[fdcst_pkg::S_B6] = b6_q;
                status[fdcst_pkg::S_B5] = b5_q;
                status[fdcst_pkg::S_B2] = b2_q;
                status[fdcst_pkg::S_DRQ] = drq_q;
            end
            default: status = 8'h00;
        endcase
    end

    // Status has no write path: a write at its address is a command
    wire logic [7:0] rdata_d = !bus.rd ? fdcst_pkg::RDATA_NONE
        : sel_st ? status
        : sel_dr ? dr_q
        : sel_ct ? {6'h00, ctrl_q} : fdcst_pkg::RDATA_NONE;
    // Format bytes pass untouched, so no index mark is ever demanded
    wire logic [7:0] dr_d = (byte_in && rd_kind) ? ev.byte_val
        : (bus.wr && sel_dr) ? bus.wdata : dr_q;

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            kind_q <= fdcst_pkg::K_POS;
            busy_q <= 1'b0;
            drq_q <= 1'b0;
            irq_q <= 1'b0;
            hld_q <= 1'b0;
            b2_q <= 1'b0;
            crc_q <= 1'b0;
            b4_q <= 1'b0;
            b5_q <= 1'b0;
            b6_q <= 1'b0;
            ctrl_q <= fdcst_pkg::CTRL_RESET;
            dr_q <= fdcst_pkg::DATA_RESET;
            rdata_q <= fdcst_pkg::RDATA_NONE;
        end else begin
            kind_q <= kind_d;
            busy_q <= busy_d;
            drq_q <= drq_d;
            irq_q <= irq_d;
            hld_q <= start || (hld_q && !master_reset_in);
            b2_q <= b2_d;
            crc_q <= crc_d;
            b4_q <= b4_d;
            b5_q <= b5_d;
            b6_q <= b6_d;
            ctrl_q <= (bus.wr && sel_ct) ? bus.wdata[1:0] : ctrl_q;
            dr_q <= dr_d;
            rdata_q <= rdata_d;
        end
    end

    // Byte timer restarts whenever the request is answered
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cell_cnt_q <= 11'h000;
            cell_q <= 1'b0;
            byte_cnt_q <= 3'h0;
        end else begin
            cell_cnt_q <= cell_wrap ? 11'h000 : cell_cnt_q + 11'h001;
            cell_q <= cell_wrap;
            if (!drq_q || dr_acc) begin
                byte_cnt_q <= 3'h0;
            end else if (cell_wrap) begin
                byte_cnt_q <= byte_cnt_q + 3'h1;
            end
        end
    end

    assign rdata = rdata_q;
    assign head_load_out = hld_q;
    assign byte_transfer_request = drq_q;
    assign command_done_irq = irq_q;
    assign bit_cell_en = cell_q;
    assign data_to_engine = dr_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_nrdy_bit: assert property (bus.rd && sel_st |=>
        rdata[7] == $past(!ready_in || master_reset_in))
        else $error("not ready bit wrong");
    a_head_engaged: assert property (bus.rd && sel_st
        && kind_q == fdcst_pkg::K_POS |=>
        rdata[5] == $past(hld_q && head_settle_in))
        else $error("head engaged bit wrong");
    a_busy_start: assert property (start |=> busy_q)
        else $error("busy not set on start");
    a_refuse_start: assert property (refused && !busy_q
        |=> !busy_q && command_done_irq)
        else $error("command ran on unready drive");
    a_drq_clear: assert property (drq_q && dr_acc && !byte_in
        |=> !byte_transfer_request)
        else $error("request not cleared by access");
    a_irq_drop: assert property (irq_q && st_rd && !done
        && !refused |=> !command_done_irq)
        else $error("interrupt held after status read");
    a_lost_after: assert property (lost_set |=> b2_q)
        else $error("lost data not flagged");
    a_cell_period: assert property (cell_q && !mfm && !slow
        && $stable(ctrl_q) |-> ##1 !cell_q [*8])
        else $error("bit cell too short");
    a_update_clr: assert property (start |=> !b4_q && !crc_q)
        else $error("errors not cleared on update");
    a_rd_zero: assert property (bus.rd && sel_st
        && kind_q == fdcst_pkg::K_RTRK |=> rdata[6:3] == 4'h0)
        else $error("unused bits not zero");
    c_refused: cover property (refused);
    c_lost: cover property (lost_set);
    c_xfer: cover property (byte_in ##[1:20] dr_acc);
    c_done_read: cover property (done ##[1:10] st_rd);

endmodule

`default_nettype wire

// File: fdcst_drive_model.sv
// Behavioural drive model: level pins and head settle delay
`timescale 1ns/10ps
`default_nettype none

module fdcst_drive_model #(
    parameter int SETTLE_CYC = 20
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic head_load_out,
    input wire logic rdy_set,
    input wire logic wp_set,
    input wire logic tr0_set,
    input wire logic idx_set,
    output logic ready_in,
    output logic write_protect_in_n,
    output logic track_zero_in_n,
    output logic index_pulse_in_n,
    output logic head_settle_in
);
    logic [7:0] settle_q;

    // ****************************************
    // Drive levels, active low where the drive says so
    // ****************************************
    assign ready_in = rdy_set;
    assign write_protect_in_n = ~wp_set;
    assign track_zero_in_n = ~tr0_set;
    assign index_pulse_in_n = ~idx_set;
    // Settle only after the head stayed loaded long enough
    assign head_settle_in = head_load_out && (settle_q == SETTLE_CYC);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            settle_q <= 8'h00;
        end else if (!head_load_out) begin
            settle_q <= 8'h00;
        end else if (settle_q != SETTLE_CYC) begin
            settle_q <= settle_q + 8'h01;
        end
    end
endmodule

`default_nettype wire

// File: tb_top.sv
// Self-checking testbench of the floppy status block
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    error_cnt++; $display("mismatch %s exp %h got %h", nm, e, g); end end

module tb_top;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    fdcst_pkg::fdcst_bus_t bus = '0;
    fdcst_pkg::fdcst_ev_t ev = '0;
    logic [7:0] rdata, data_to_engine, s;
    logic master_reset_in = 1'b0;
    logic rdy = 1'b1, wp = 1'b0, tr0 = 1'b0, idx = 1'b0;
    wire logic ready_in, wp_n, tr0_n, idx_n, settle;
    logic head_load_out, byte_transfer_request, command_done_irq;
    logic bit_cell_en;
    int error_cnt = 0;
    int n_checks = 0;
    int n;
    logic [7:0] fmt_sd [14] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'hFE, 8'h00, 8'h00, 8'h01, 8'h00, 8'hF7};
    logic [7:0] fmt_dd [14] = '{8'h4E, 8'h4E, 8'h00, 8'h00, 8'hF5, 8'hF5,
        8'hF5, 8'hFE, 8'h00, 8'h00, 8'h01, 8'h01, 8'hF7, 8'h4E};

    always #2.5 ref_clk = ~ref_clk;

    fdcst_core fdcst_core_i (.ref_clk(ref_clk), .rstn(rstn), .bus(bus),
        .rdata(rdata), .ev(ev), .ready_in(ready_in),
        .master_reset_in(master_reset_in), .write_protect_in_n(wp_n),
        .head_settle_in(settle), .track_zero_in_n(tr0_n),
        .index_pulse_in_n(idx_n), .head_load_out(head_load_out),
        .byte_transfer_request(byte_transfer_request),
        .command_done_irq(command_done_irq), .bit_cell_en(bit_cell_en),
        .data_to_engine(data_to_engine));

    fdcst_drive_model fdcst_drive_model_i (.ref_clk(ref_clk), .rstn(rstn),
        .head_load_out(head_load_out), .rdy_set(rdy), .wp_set(wp),
        .tr0_set(tr0), .idx_set(idx), .ready_in(ready_in),
        .write_protect_in_n(wp_n), .track_zero_in_n(tr0_n),
        .index_pulse_in_n(idx_n), .head_settle_in(settle));

    // ****************************************
    // Bus and event tasks
    // ****************************************
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk) bus <= '0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge ref_clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk) bus <= '0;
        #1 d = rdata;
    endtask

    task automatic evp(input fdcst_pkg::fdcst_ev_t v);
        @(posedge ref_clk) ev <= v;
        @(posedge ref_clk) ev <= '0;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_position();
        wp = 1'b1;
        tr0 = 1'b1;
        wr(fdcst_pkg::ADDR_STATUS_CMD, {5'h00, fdcst_pkg::CMD_POSITION});
        cyc(30);
        rd(fdcst_pkg::ADDR_STATUS_CMD, s);
        // Settled head, protected, track zero, busy
        `CHK("pos status", 8'h65, s)
        idx = 1'b1;
        evp('{seek_err: 1'b1, crc_err: 1'b1, default: '0});
        evp('{done: 1'b1, default: '0});
        cyc(2);
        `CHK("irq", 1'b1, command_done_irq)
        rd(fdcst_pkg::ADDR_STATUS_CMD, s);
        `CHK("pos end", 8'h1E, s & 8'h1F)
        cyc(1);
        `CHK("irq drop", 1'b0, command_done_irq)
        wp = 1'b0;
        tr0 = 1'b0;
        idx = 1'b0;
    endtask

    task automatic t_read_sector();
        wr(fdcst_pkg::ADDR_STATUS_CMD, {5'h00, fdcst_pkg::CMD_RD_SEC});
        evp('{byte_stb: 1'b1, byte_val: 8'h5A, default: '0});
        cyc(1);
        `CHK("drq", 1'b1, byte_transfer_request)
        rd(fdcst_pkg::ADDR_STATUS_CMD, s);
        `CHK("rsec busy", 8'h03, s)
        rd(fdcst_pkg::ADDR_DATA, s);
        `CHK("rsec data", 8'h5A, s)
        cyc(1);
        `CHK("drq clr", 1'b0, byte_transfer_request)
        evp('{deleted_mark: 1'b1, record_not_found: 1'b1, crc_err: 1'b1, default: '0});
        evp('{done: 1'b1, default: '0});
        cyc(2);
        rd(fdcst_pkg::ADDR_STATUS_CMD, s);
        `CHK("rsec end", 8'h38, s)
    endtask

    task automatic t_write_sector();
        wp = 1'b1;
        wr(fdcst_pkg::ADDR_STATUS_CMD, {5'h00, fdcst_pkg::CMD_WR_SEC});
        cyc(6000);
        rd(fdcst_pkg::ADDR_STATUS_CMD, s);
        `CHK("wsec early", 8'h43, s)
        cyc(1000);
        rd(fdcst_pkg::ADDR_STATUS_CMD, s);
        `CHK("wsec lost", 8'h04, s & 8'h04)
        wr(fdcst_pkg::ADDR_DATA, 8'hA5);
        cyc(1);
        `CHK("wdata", 8'hA5, data_to_engine)
        `CHK("drq wr clr", 1'b0, byte_transfer_request)
        wr(fdcst_pkg::ADDR_STATUS_CMD, {5'h00, fdcst_pkg::CMD_FORCE});
        cyc(2);
        `CHK("force irq", 1'b1, command_done_irq)
        rd(fdcst_pkg::ADDR_STATUS_CMD, s);
        `CHK("force idle", 8'h00, s & 8'h01)
        wp = 1'b0;
    endtask

    task automatic t_not_ready();
        rdy = 1'b0;
        wr(fdcst_pkg::ADDR_STATUS_CMD, {5'h00, fdcst_pkg::CMD_RD_TRK});
        cyc(2);
        `CHK("nrdy irq", 1'b1, command_done_irq)
        rd(fdcst_pkg::ADDR_STATUS_CMD, s);
        `CHK("nrdy status", 8'h80, s & 8'h81)
        rdy = 1'b1;
        master_reset_in = 1'b1;
        rd(fdcst_pkg::ADDR_STATUS_CMD, s);
        `CHK("mr status", 8'h80, s & 8'h81)
        master_reset_in = 1'b0;
        wr(fdcst_pkg::ADDR_STATUS_CMD, {5'h00, fdcst_pkg::CMD_RD_TRK});
        rd(fdcst_pkg::ADDR_STATUS_CMD, s);
        `CHK("rtrk zero", 8'h01, s & 8'h79)
        wr(fdcst_pkg::ADDR_STATUS_CMD, {5'h00, fdcst_pkg::CMD_FORCE});
        rd(2'h3, s);
        `CHK("unmapped", 8'h00, s)
    endtask

    // Host side of a track format: one byte per request, gaps shortened
    task automatic t_write_track(input logic dd);
        wr(fdcst_pkg::ADDR_CTRL, {7'h00, dd});
        wr(fdcst_pkg::ADDR_STATUS_CMD, {5'h00, fdcst_pkg::CMD_WR_TRK});
        for (int i = 0; i < 14; i++) begin
            wr(fdcst_pkg::ADDR_DATA, dd ? fmt_dd[i] : fmt_sd[i]);
            cyc(1);
            if (dd) begin
                `CHK("fmt dd", fmt_dd[i], data_to_engine)
            end else begin
                `CHK("fmt sd", fmt_sd[i], data_to_engine)
            end
            evp('{byte_stb: 1'b1, default: '0});
        end
        evp('{done: 1'b1, default: '0});
        cyc(2);
        rd(fdcst_pkg::ADDR_STATUS_CMD, s);
        `CHK("wtrk end", 8'h00, s)
    endtask

    // Period between cell strobes for the control setting passed in c
    task automatic t_cells(input logic [7:0] c, input int exp);
        wr(fdcst_pkg::ADDR_CTRL, c);
        @(posedge bit_cell_en);
        n = 0;
        // Sample a settled strobe, never in the edge that launches it
        do begin
            cyc(1);
            n++;
        end while (bit_cell_en !== 1'b1 && n < 4000);
        `CHK("cell period", exp, n)
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog sized well past the longest wait of the sequence
    initial begin
        #200000;
        error_cnt++;
        final_report();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        cyc(1);
        `CHK("rst irq", 1'b0, command_done_irq)
        t_position();
        t_read_sector();
        t_write_sector();
        t_write_track(1'b0);
        t_write_track(1'b1);
        t_not_ready();
        t_cells(8'h00, fdcst_pkg::CELL_FM_CYC);
        t_cells(8'h01, fdcst_pkg::CELL_MFM_CYC);
        t_cells(8'h03, 2 * fdcst_pkg::CELL_MFM_CYC);
        final_report();
    end
endmodule

`default_nettype wire
